// *** verilog/pic_pkg.sv ***
`default_nettype none

package pic_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int VEC_W = 14;
    localparam int NSRC = 10;
    localparam int NLVL = 7;

    // ------------------------------------------------------------
    // Source indices
    // ------------------------------------------------------------
    localparam int SRC_P0 = 0;
    localparam int SRC_P1 = 1;
    localparam int SRC_TA = 2;
    localparam int SRC_TB = 3;
    localparam int SRC_P2 = 4;
    localparam int SRC_TC = 5;
    localparam int SRC_P3 = 6;
    localparam int SRC_TD = 7;
    localparam int SRC_AD = 8;
    localparam int SRC_SR = 9;

    // ------------------------------------------------------------
    // Nibble addresses in data memory
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADR_CTL0 = 10'h000;
    localparam logic [ADDR_W-1:0] ADR_CTL1 = 10'h001;
    localparam logic [ADDR_W-1:0] ADR_CTL2 = 10'h002;
    localparam logic [ADDR_W-1:0] ADR_CTL3 = 10'h003;
    localparam logic [ADDR_W-1:0] ADR_CTL22 = 10'h022;
    localparam logic [ADDR_W-1:0] ADR_CTL23 = 10'h023;
    localparam logic [ADDR_W-1:0] ADR_ESEL_A = 10'h026;
    localparam logic [ADDR_W-1:0] ADR_ESEL_B = 10'h027;

    // Flag location per source; its mask sits one bit above
    localparam logic [ADDR_W-1:0] FLAG_ADDR [NSRC] = '{
        ADR_CTL0, ADR_CTL1, ADR_CTL1, ADR_CTL2, ADR_CTL22,
        ADR_CTL2, ADR_CTL22, ADR_CTL3, ADR_CTL3, ADR_CTL23};
    localparam logic [1:0] FLAG_BIT [NSRC] = '{
        2'h2, 2'h0, 2'h2, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h2, 2'h2};
    localparam logic [1:0] MASK_OFS = 2'h1;
    localparam logic [1:0] EN_BIT = 2'h0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [NSRC-1:0] FLAG_RST = 10'h000;
    localparam logic [NSRC-1:0] MASK_RST = 10'h3ff;
    localparam logic EN_RST = 1'h0;
    // Pin idle levels: lines 0/1 high, lines 2/3 low
    localparam logic [3:0] PIN_RST = 4'h3;
    localparam logic [3:0] ESEL_RST = 4'h0;
    localparam logic [3:0] NIB_ZERO = 4'h0;

    // ------------------------------------------------------------
    // Edge select codes (two bits per pin)
    // ------------------------------------------------------------
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ------------------------------------------------------------
    // Vectors, highest priority first
    // ------------------------------------------------------------
    localparam logic [VEC_W-1:0] VEC_RESET = 14'h0000;
    localparam logic [VEC_W-1:0] LVL_VEC [NLVL] = '{
        14'h0002, 14'h0004, 14'h0006, 14'h0008, 14'h000a, 14'h000c,
        14'h000e};

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE, OP_WRITE, OP_READ, OP_BSET, OP_BCLR, OP_BTEST
    } pic_op_e;

    typedef struct packed {
        pic_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [1:0] bitSel;
        logic [3:0] wdata;
    } pic_access_s;

    typedef struct packed {
        logic [3:0] timerOverflow;
        logic serialDone;
        logic converterDone;
    } pic_events_s;

    typedef enum logic [1:0] {
        ST_IDLE, ST_FINISH, ST_CLRIE, ST_JUMP
    } pic_state_e;

endpackage

`default_nettype wire

// *** verilog/pic_controller.sv ***
// What this block does
// - Takes ten sources: four pins, four timers, serial and converter.
// - Every source has flag, mask and vector; one global enable gates all.
// - Vectors shared: timer B/pin 2, timer C/pin 3, converter/serial.
// - Flags, masks, enable at nibbles 000-003, 022-023; bit ops reach them.
// - Software cannot set a flag; only its event sets it.
// - Reset clears enable and flags, sets all masks.
// - Flag set and mask clear requests; serviced only with enable set.
// - Priority encoder gives winner's vector; higher always wins.
// - Levels: pin0, pin1, timer A, B/pin2, C/pin3, D, converter/serial.
// - Reset and stop-cancel vector to zero; stop-cancel only in stop mode.
// - Shared vector active when either member is flagged and unmasked.
// - Entry: finish instruction, clear enable, then jump to vector.
// - Carry, status and counter pushed during entry cycles two and three.
// - Enable at 000 bit 0; entry clears it, return sets it.
// - Pins 0 and 1 flag on falling edge of active-low inputs.
// - Pins 2 and 3 flag on selected edge; selects for both pins at 026.
// - Timer overflow pulses set the timer flags.
// - Serial flag sets on transfer done or suspend.
`timescale 1ns/1ps
`default_nettype none

module pic_controller (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Data memory bit access
    input wire pic_pkg::pic_access_s access,
    output logic [3:0] rdData,
    output logic rdValid,
    output logic rdHit,
    // Request sources
    input wire logic ext_line_zero_n,
    input wire logic ext_line_one_n,
    input wire logic ext_line_two,
    input wire logic ext_line_three,
    input wire pic_pkg::pic_events_s events,
    // Stop mode wake
    input wire logic stopMode,
    input wire logic stop_cancel_input,
    output logic wakeReq,
    output logic [pic_pkg::VEC_W-1:0] wakeVector,
    // Core sequencer
    output logic intReq,
    output logic [pic_pkg::VEC_W-1:0] reqVector,
    input wire logic intAck,
    input wire logic return_from_handler_instr,
    output logic finishInstr,
    output logic pushStack,
    output logic jumpValid,
    output logic [pic_pkg::VEC_W-1:0] jumpVector,
    // State visible to other logic
    output logic global_enable_flag,
    output logic [3:0] edge_select_pin2_pin3_b
);
    import pic_pkg::*;

    logic [NSRC-1:0] flags, source_mask_bit, setEv, active;
    logic [3:0] edge_select_pin2_pin3_a;
    logic [NLVL-1:0] lvlActive;
    logic [VEC_W-1:0] next_vector;
    logic [3:0] pinSync1, pinSync2, pinPrev, pinFall, pinRise;
    logic stopSync1, stopSync2, anyActive, ackTaken, swWrite, next_hit;
    pic_state_e state;
    logic [3:0] next_rd;

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync1 <= PIN_RST;
            pinSync2 <= PIN_RST;
            pinPrev <= PIN_RST;
        end else begin
            pinSync1 <= {ext_line_three, ext_line_two, ext_line_one_n,
                         ext_line_zero_n};
            pinSync2 <= pinSync1;
            pinPrev <= pinSync2;
        end
    end

    assign pinFall = pinPrev & ~pinSync2;
    assign pinRise = ~pinPrev & pinSync2;

    // Edge select decode
    function automatic logic edgeHit(input logic [1:0] sel,
                                     input logic rise,
                                     input logic fall);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            EDGE_NONE: hit = 1'b0;
            EDGE_FALL: hit = fall;
            EDGE_RISE: hit = rise;
            EDGE_BOTH: hit = rise | fall;
        endcase
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Hardware set events
    // ------------------------------------------------------------
    always_comb begin
        setEv = '0;
        setEv[SRC_P0] = pinFall[0];
        setEv[SRC_P1] = pinFall[1];
        setEv[SRC_P2] = edgeHit(edge_select_pin2_pin3_a[1:0],
                                pinRise[2], pinFall[2]);
        setEv[SRC_P3] = edgeHit(edge_select_pin2_pin3_a[3:2],
                                pinRise[3], pinFall[3]);
        setEv[SRC_TA] = events.timerOverflow[0];
        setEv[SRC_TB] = events.timerOverflow[1];
        setEv[SRC_TC] = events.timerOverflow[2];
        setEv[SRC_TD] = events.timerOverflow[3];
        setEv[SRC_SR] = events.serialDone;
        setEv[SRC_AD] = events.converterDone;
    end

    // ------------------------------------------------------------
    // Flags and masks under bit access
    // ------------------------------------------------------------
    assign swWrite = access.op == OP_WRITE || access.op == OP_BSET ||
                     access.op == OP_BCLR;

    // New value of bit b at the accessed nibble
    function automatic logic bitValue(input logic [1:0] b);
        return access.op == OP_WRITE ? access.wdata[b] : access.op == OP_BSET;
    endfunction

    for (genvar i = 0; i < NSRC; i++) begin : g_src
        logic hitNib, flagWr, maskWr;
        logic [1:0] maskBit;
        assign maskBit = FLAG_BIT[i] + MASK_OFS;
        assign hitNib = swWrite && access.addr == FLAG_ADDR[i];
        assign flagWr = hitNib && (access.op == OP_WRITE ||
                                   access.bitSel == FLAG_BIT[i]);
        assign maskWr = hitNib && (access.op == OP_WRITE ||
                                   access.bitSel == maskBit);

        // Set wins over clear; a written one is ignored
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                flags[i] <= FLAG_RST[i];
            end else if (setEv[i]) begin
                flags[i] <= 1'b1;
            end else if (flagWr && !bitValue(FLAG_BIT[i])) begin
                flags[i] <= 1'b0;
            end
        end

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                source_mask_bit[i] <= MASK_RST[i];
            end else if (maskWr) begin
                source_mask_bit[i] <= bitValue(maskBit);
            end
        end

        assign active[i] = flags[i] & ~source_mask_bit[i];
    end

    // ------------------------------------------------------------
    // Global enable
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            global_enable_flag <= EN_RST;
        end else if (return_from_handler_instr) begin
            global_enable_flag <= 1'b1;
        end else if (state == ST_FINISH) begin
            global_enable_flag <= 1'b0;
        end else if (swWrite && access.addr == ADR_CTL0 &&
                     (access.op == OP_WRITE || access.bitSel == EN_BIT)) begin
            global_enable_flag <= bitValue(EN_BIT);
        end
    end

    // ------------------------------------------------------------
    // Edge select registers (write only)
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_select_pin2_pin3_a <= ESEL_RST;
            edge_select_pin2_pin3_b <= ESEL_RST;
        end else if (access.op == OP_WRITE) begin
            if (access.addr == ADR_ESEL_A) begin
                edge_select_pin2_pin3_a <= access.wdata;
            end
            if (access.addr == ADR_ESEL_B) begin
                edge_select_pin2_pin3_b <= access.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Read and bit test
    // ------------------------------------------------------------
    always_comb begin
        next_rd = NIB_ZERO;
        next_hit = access.addr == ADR_CTL0 || access.addr == ADR_CTL1 ||
                   access.addr == ADR_CTL2 || access.addr == ADR_CTL3 ||
                   access.addr == ADR_CTL22 || access.addr == ADR_CTL23 ||
                   access.addr == ADR_ESEL_A || access.addr == ADR_ESEL_B;
        if (access.addr == ADR_CTL0) begin
            next_rd[EN_BIT] = global_enable_flag;
        end
        for (int i = 0; i < NSRC; i++) begin
            if (access.addr == FLAG_ADDR[i]) begin
                next_rd[FLAG_BIT[i]] = flags[i];
                next_rd[2'(FLAG_BIT[i] + MASK_OFS)] = source_mask_bit[i];
            end
        end
        if (access.op == OP_BTEST) begin
            next_rd = {3'h0, next_rd[access.bitSel]};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= NIB_ZERO;
            rdValid <= 1'b0;
            rdHit <= 1'b0;
        end else begin
            rdValid <= access.op == OP_READ || access.op == OP_BTEST;
            rdHit <= next_hit;
            rdData <= (access.op == OP_READ || access.op == OP_BTEST) ?
                      next_rd : NIB_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Priority encoder
    // ------------------------------------------------------------
    always_comb begin
        lvlActive[0] = active[SRC_P0];
        lvlActive[1] = active[SRC_P1];
        lvlActive[2] = active[SRC_TA];
        lvlActive[3] = active[SRC_TB] | active[SRC_P2];
        lvlActive[4] = active[SRC_TC] | active[SRC_P3];
        lvlActive[5] = active[SRC_TD];
        lvlActive[6] = active[SRC_AD] | active[SRC_SR];
        next_vector = LVL_VEC[NLVL-1];
        for (int l = NLVL - 1; l >= 0; l--) begin
            if (lvlActive[l]) begin
                next_vector = LVL_VEC[l];
            end
        end
    end

    assign anyActive = |lvlActive;

    // ------------------------------------------------------------
    // Entry sequence
    // ------------------------------------------------------------
    assign ackTaken = state == ST_IDLE && intReq && intAck;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: if (ackTaken) state <= ST_FINISH;
                ST_FINISH: state <= ST_CLRIE;
                ST_CLRIE: state <= ST_JUMP;
                ST_JUMP: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            intReq <= 1'b0;
            reqVector <= VEC_RESET;
        end else begin
            intReq <= state == ST_IDLE && !ackTaken &&
                      global_enable_flag && anyActive;
            if (!ackTaken) begin
                reqVector <= next_vector;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            finishInstr <= 1'b0;
            pushStack <= 1'b0;
            jumpValid <= 1'b0;
            jumpVector <= VEC_RESET;
        end else begin
            finishInstr <= ackTaken;
            pushStack <= state == ST_FINISH || state == ST_CLRIE;
            jumpValid <= state == ST_CLRIE;
            if (ackTaken) begin
                jumpVector <= reqVector;
            end
        end
    end

    // ------------------------------------------------------------
    // Stop cancel wake
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stopSync1 <= 1'b0;
            stopSync2 <= 1'b0;
            wakeReq <= 1'b0;
            wakeVector <= VEC_RESET;
        end else begin
            stopSync1 <= stop_cancel_input;
            stopSync2 <= stopSync1;
            wakeReq <= stopMode && stopSync2;
            wakeVector <= VEC_RESET;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_ack;
        ackTaken;
    endsequence

    sequence s_entry;
        finishInstr && !pushStack ##1 pushStack && !global_enable_flag
        ##1 pushStack && jumpValid;
    endsequence

    entry_order_a: assert property (s_ack |=> s_entry)
        else $error("entry sequence out of order");
    push_len_a: assert property (
        $rose(pushStack) |-> pushStack [*2] ##1 !pushStack)
        else $error("stack push not two cycles");
    no_sw_set_a: assert property (
        !flags[SRC_TA] && !setEv[SRC_TA] |=> !flags[SRC_TA])
        else $error("flag set without event");
    timer_set_a: assert property (
        events.timerOverflow[0] |=> flags[SRC_TA])
        else $error("timer flag not set");
    pin0_fall_a: assert property (pinFall[0] |=> flags[SRC_P0])
        else $error("pin zero flag not set");
    req_gate_a: assert property (
        intReq |-> $past(global_enable_flag) && $past(anyActive))
        else $error("request without enable");
    prio_top_a: assert property (
        intReq && $past(lvlActive[0]) |-> reqVector == LVL_VEC[0])
        else $error("top source lost priority");
    shared_vec_a: assert property (
        intReq && $past(active[SRC_P2]) && $past(lvlActive[2:0] == 3'h0)
        |-> reqVector == LVL_VEC[3])
        else $error("shared vector wrong");
    return_en_a: assert property (
        return_from_handler_instr |=> global_enable_flag)
        else $error("return did not enable");
    wake_gate_a: assert property (
        wakeReq |-> $past(stopMode) && wakeVector == VEC_RESET)
        else $error("wake outside stop mode");

endmodule

`default_nettype wire

// *** testbench/pic_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pic_core_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Sequencer side
    input wire logic ackOn,
    input wire logic intReq,
    output logic intAck
);
    // Acks a waiting request once; ackOn low makes the core slow
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            intAck <= 1'b0;
        end else begin
            intAck <= ackOn && intReq && !intAck;
        end
    end
endmodule

`default_nettype wire

// *** testbench/pic_controller_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module pic_controller_bench;
    import pic_pkg::*;

    logic sys_clk, rst_n, rdValid, rdHit, stopMode, stop_cancel_input;
    logic ext_line_zero_n, ext_line_one_n, ext_line_two, ext_line_three;
    logic wakeReq, intReq, intAck, return_from_handler_instr, ackOn;
    logic finishInstr, pushStack, jumpValid, global_enable_flag;
    logic [3:0] rdData, edge_select_pin2_pin3_b;
    logic [VEC_W-1:0] wakeVector, reqVector, jumpVector;
    pic_access_s access;
    pic_events_s events;
    int miscompares, checkCount;
    localparam logic [VEC_W-1:0] TV [6] = '{14'h0006, 14'h0008,
        14'h000a, 14'h000c, 14'h000e, 14'h000e};
    localparam logic [ADDR_W-1:0] TA [6] = '{ADR_CTL1, ADR_CTL2,
        ADR_CTL2, ADR_CTL3, ADR_CTL3, ADR_CTL23};
    localparam logic [1:0] TB [6] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h2};

    pic_controller uut (.sys_clk(sys_clk), .rst_n(rst_n), .access(access),
        .rdData(rdData), .rdValid(rdValid), .rdHit(rdHit),
        .ext_line_zero_n(ext_line_zero_n), .ext_line_one_n(ext_line_one_n),
        .ext_line_two(ext_line_two), .ext_line_three(ext_line_three),
        .events(events), .stopMode(stopMode),
        .stop_cancel_input(stop_cancel_input), .wakeReq(wakeReq),
        .wakeVector(wakeVector), .intReq(intReq), .reqVector(reqVector),
        .intAck(intAck),
        .return_from_handler_instr(return_from_handler_instr),
        .finishInstr(finishInstr), .pushStack(pushStack),
        .jumpValid(jumpValid), .jumpVector(jumpVector),
        .global_enable_flag(global_enable_flag),
        .edge_select_pin2_pin3_b(edge_select_pin2_pin3_b));

    pic_core_model core (.sys_clk(sys_clk), .rst_n(rst_n), .ackOn(ackOn),
        .intReq(intReq), .intAck(intAck));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic acc(input pic_op_e op, input logic [ADDR_W-1:0] ad,
                       input logic [1:0] b, input logic [3:0] d);
        @(posedge sys_clk);
        access <= '{op: op, addr: ad, bitSel: b, wdata: d};
        @(posedge sys_clk);
        access <= '{op: OP_NONE, addr: '0, bitSel: '0, wdata: '0};
        #1;
    endtask

    task automatic rd(input pic_op_e op, input logic [ADDR_W-1:0] ad,
                      input logic [1:0] b, input logic [3:0] e,
                      input logic h);
        acc(op, ad, b, 4'h0);
        chk(rdValid, 1'b1);
        chk(rdData, e);
        chk(rdHit, h);
    endtask

    task automatic ev(input pic_events_s e);
        @(posedge sys_clk);
        events <= e;
        @(posedge sys_clk);
        events <= '0;
        #1;
    endtask

    // Waits for a request, follows the entry, clears the flag as handler
    task automatic svc(input logic [VEC_W-1:0] v, input logic [ADDR_W-1:0] ad,
                       input logic [1:0] b);
        int n;
        n = 0;
        while (intReq !== 1'b1 && n < 40) begin
            tick();
            n++;
        end
        chk(reqVector, v);
        n = 0;
        while (finishInstr !== 1'b1 && n < 10) begin
            tick();
            n++;
        end
        chk(finishInstr, 1'b1);
        chk(intReq, 1'b0);
        tick();
        chk(pushStack, 1'b1);
        chk(global_enable_flag, 1'b0);
        tick();
        chk(pushStack, 1'b1);
        chk(jumpValid, 1'b1);
        chk(jumpVector, v);
        acc(OP_BCLR, ad, b, 4'h0);
    endtask

    task automatic ret;
        @(posedge sys_clk);
        return_from_handler_instr <= 1'b1;
        @(posedge sys_clk);
        return_from_handler_instr <= 1'b0;
        #1;
        chk(global_enable_flag, 1'b1);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        finish_test();
    end

    initial begin
        rst_n = 1'h0;
        access = '{op: OP_NONE, addr: '0, bitSel: '0, wdata: '0};
        events = '0;
        {ackOn, return_from_handler_instr} = 2'h2;
        {stopMode, stop_cancel_input, ext_line_three, ext_line_two,
         ext_line_one_n, ext_line_zero_n} = 6'h03;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'h1;
        repeat (4) tick();
        reset_values();
        sw_no_set();
        pending_events();
        ext_pins_low();
        ext_pins_edges();
        stop_wake();
        finish_test();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic reset_values;
        rd(OP_READ, ADR_CTL0, 2'h0, 4'h8, 1'b1);
        rd(OP_READ, ADR_CTL1, 2'h0, 4'ha, 1'b1);
        rd(OP_READ, ADR_CTL2, 2'h0, 4'ha, 1'b1);
        rd(OP_READ, ADR_CTL3, 2'h0, 4'ha, 1'b1);
        rd(OP_READ, ADR_CTL22, 2'h0, 4'ha, 1'b1);
        rd(OP_READ, ADR_CTL23, 2'h0, 4'h8, 1'b1);
        rd(OP_READ, 10'h010, 2'h0, 4'h0, 1'b0);
        rd(OP_READ, ADR_ESEL_A, 2'h0, 4'h0, 1'b1);
    endtask

    task automatic sw_no_set;
        acc(OP_BSET, ADR_CTL1, 2'h0, 4'h0);
        acc(OP_WRITE, ADR_CTL23, 2'h0, 4'hf);
        rd(OP_READ, ADR_CTL1, 2'h0, 4'ha, 1'b1);
        rd(OP_READ, ADR_CTL23, 2'h0, 4'h8, 1'b1);
        acc(OP_WRITE, ADR_ESEL_B, 2'h0, 4'h9);
        chk(edge_select_pin2_pin3_b, 4'h9);
    endtask

    // Timer, converter and serial events while disabled
    task automatic pending_events;
        ev('{timerOverflow: 4'hf, serialDone: 1'b1, converterDone: 1'b1});
        for (int i = 0; i < 6; i++) begin
            acc(OP_BCLR, TA[i], TB[i] + 2'h1, 4'h0);
            rd(OP_BTEST, TA[i], TB[i], 4'h1, 1'b1);
        end
        chk(intReq, 1'b0);
        acc(OP_BSET, ADR_CTL0, 2'h0, 4'h0);
        for (int i = 0; i < 6; i++) begin
            svc(TV[i], TA[i], TB[i]);
            ret();
        end
    endtask

    // Drives stop mode, stop-cancel and the four pins at a clock edge
    task automatic pins(input logic [5:0] v);
        @(posedge sys_clk);
        {stopMode, stop_cancel_input, ext_line_three, ext_line_two,
         ext_line_one_n, ext_line_zero_n} <= v;
        #1;
    endtask

    // Pins 0 and 1 together: higher one first; slow core holds request
    task automatic ext_pins_low;
        acc(OP_BCLR, ADR_CTL0, 2'h3, 4'h0);
        acc(OP_BCLR, ADR_CTL1, 2'h1, 4'h0);
        ackOn <= 1'h0;
        pins(6'h00);
        repeat (8) tick();
        chk(intReq, 1'h1);
        chk(finishInstr, 1'h0);
        ackOn <= 1'h1;
        svc(14'h0002, ADR_CTL0, 2'h2);
        pins(6'h03);
        ret();
        svc(14'h0004, ADR_CTL1, 2'h0);
        ret();
    endtask

    // Pin 2 rising only, pin 3 both; then pin 2 falling, pin 3 none
    task automatic ext_pins_edges;
        acc(OP_WRITE, ADR_ESEL_A, 2'h0, 4'he);
        acc(OP_BCLR, ADR_CTL22, 2'h3, 4'h0);
        pins(6'h07);
        repeat (5) tick();
        rd(OP_BTEST, ADR_CTL22, 2'h0, 4'h1, 1'h1);
        acc(OP_BCLR, ADR_CTL22, 2'h1, 4'h0);
        svc(14'h0008, ADR_CTL22, 2'h0);
        ret();
        pins(6'h0b);
        svc(14'h000a, ADR_CTL22, 2'h2);
        ret();
        pins(6'h03);
        svc(14'h000a, ADR_CTL22, 2'h2);
        ret();
        repeat (2) tick();
        chk(intReq, 1'h0);
        acc(OP_WRITE, ADR_ESEL_A, 2'h0, 4'h1);
        pins(6'h0f);
        repeat (5) tick();
        chk(intReq, 1'h0);
        pins(6'h0b);
        svc(14'h0008, ADR_CTL22, 2'h0);
        ret();
        pins(6'h03);
        repeat (5) tick();
        chk(intReq, 1'h0);
    endtask

    // Stop-cancel wake only in stop mode
    task automatic stop_wake;
        pins(6'h13);
        repeat (5) tick();
        chk(wakeReq, 1'h0);
        pins(6'h33);
        repeat (5) tick();
        chk(wakeReq, 1'h1);
        chk(wakeVector, VEC_RESET);
        pins(6'h03);
        repeat (5) tick();
        chk(wakeReq, 1'h0);
    endtask
endmodule

`default_nettype wire
